// ===== rtl/ssf_cfg.svh
`ifndef SSF_CFG_SVH
`define SSF_CFG_SVH

`define SSF_FANOUT_DEFAULT 2
`define SSF_GATE_DEFAULT 1
`define SSF_DATA_W_DEFAULT 8
`define SSF_SYMBOL_W_DEFAULT 8
`define SSF_PACKETS_DEFAULT 0
`define SSF_CHANNEL_DEFAULT 0
`define SSF_CHANNEL_W_DEFAULT 1
`define SSF_MAX_CHAN_DEFAULT 1
`define SSF_ERROR_DEFAULT 0
`define SSF_ERROR_W_DEFAULT 1

`define SSF_OFF_CTRL 12'h000
`define SSF_OFF_STATUS 12'h004
`define SSF_OFF_BEATS 12'h008
`define SSF_CTRL_CLR_BIT 0
`define SSF_STAT_INVALID_BIT 0
`define SSF_STAT_INREADY_BIT 1
`define SSF_STAT_OUTREADY_LSB 16
`define SSF_RDATA_RESET 32'h0000_0000
`define SSF_BEATS_RESET 32'h0000_0000

`endif

// ===== rtl/ssf_pkg.sv
`default_nettype none

package ssf_pkg;

    typedef enum logic [1:0] {
        SSF_REG_CTRL,
        SSF_REG_STATUS,
        SSF_REG_BEATS,
        SSF_REG_NONE
    } ssf_reg_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic [31:0] beats;
    } ssf_state_t;

    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } ssf_apb_req_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } ssf_apb_rsp_t;

endpackage : ssf_pkg

`default_nettype wire

// ===== rtl/ssf_splitter_fanout.sv
// Operation
// - Input ready is the AND of every output ready.
// - With gating on, any output dropping ready drops valid on all the other outputs.
// - With gating off, every output valid is a plain copy of input valid.
// - Splitting, ready combining and valid gating are combinational with no added latency.
// - The output count is a build-time parameter from 1 to 16, default 2.
// - The valid gating option is a build-time parameter of 0 or 1, default 1.
// - The data width is a build-time parameter from 1 to 512, default 8.
// - The symbol width is a build-time parameter from 1 to 512, default 8.
// - With packets enabled, start, end and empty are copied to every output.
// - An optional channel signal of 0 to 8 bits for up to 255 channels is copied when enabled.
// - An optional error signal of 0 to 31 bits is copied when enabled, zero width meaning none.
// - Every input signal except valid and ready appears unchanged on each output; packet, channel and error signals only when enabled.
// - The clock only names the domain; the stream path holds no storage on it. The APB registers and the beat count are clocked on ref_clk.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ssf_cfg.svh"

module ssf_splitter_fanout #(
    parameter int FANOUT_COUNT = `SSF_FANOUT_DEFAULT,
    parameter int QUALIFY_VALID = `SSF_GATE_DEFAULT,
    parameter int DATA_WIDTH = `SSF_DATA_W_DEFAULT,
    parameter int BITS_PER_SYMBOL = `SSF_SYMBOL_W_DEFAULT,
    parameter int USE_PACKETS = `SSF_PACKETS_DEFAULT,
    parameter int USE_CHANNEL = `SSF_CHANNEL_DEFAULT,
    parameter int CHANNEL_WIDTH = `SSF_CHANNEL_W_DEFAULT,
    parameter int MAX_CHANNELS = `SSF_MAX_CHAN_DEFAULT,
    parameter int USE_ERROR = `SSF_ERROR_DEFAULT,
    parameter int ERROR_WIDTH = `SSF_ERROR_W_DEFAULT,
    localparam int CHAN_W = (CHANNEL_WIDTH < 1) ? 1 : CHANNEL_WIDTH,
    localparam int ERR_W = (ERROR_WIDTH < 1) ? 1 : ERROR_WIDTH,
    localparam int SYMS = (DATA_WIDTH / BITS_PER_SYMBOL < 1) ? 1 : DATA_WIDTH / BITS_PER_SYMBOL,
    localparam int EMPTY_W = (SYMS < 2) ? 1 : $clog2(SYMS)
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Stream sink side
    input wire logic inValid,
    output logic inReady,
    input wire logic [DATA_WIDTH-1:0] inData,
    input wire logic inStartOfPacket,
    input wire logic inEndOfPacket,
    input wire logic [EMPTY_W-1:0] inEmpty,
    input wire logic [CHAN_W-1:0] inChannel,
    input wire logic [ERR_W-1:0] inError,
    // Stream source side, one lane per output
    output logic [FANOUT_COUNT-1:0] outValid,
    input wire logic [FANOUT_COUNT-1:0] outReady,
    output logic [FANOUT_COUNT-1:0][DATA_WIDTH-1:0] outData,
    output logic [FANOUT_COUNT-1:0] outStartOfPacket,
    output logic [FANOUT_COUNT-1:0] outEndOfPacket,
    output logic [FANOUT_COUNT-1:0][EMPTY_W-1:0] outEmpty,
    output logic [FANOUT_COUNT-1:0][CHAN_W-1:0] outChannel,
    output logic [FANOUT_COUNT-1:0][ERR_W-1:0] outError
);
    import ssf_pkg::*;

    localparam bit HAS_CHAN = (USE_CHANNEL == 1) && (CHANNEL_WIDTH > 0);
    localparam bit HAS_ERR = (USE_ERROR == 1) && (ERROR_WIDTH > 0);

    // Build-time ranges; a bad setting stops elaboration
    if (FANOUT_COUNT < 1 || FANOUT_COUNT > 16)
    begin : g_bad_fanout
        $error("fanout count out of range");
    end
    if (QUALIFY_VALID != 0 && QUALIFY_VALID != 1)
    begin : g_bad_gate
        $error("valid gating option out of range");
    end
    if (DATA_WIDTH < 1 || DATA_WIDTH > 512)
    begin : g_bad_data
        $error("data width out of range");
    end
    if (BITS_PER_SYMBOL < 1 || BITS_PER_SYMBOL > 512)
    begin : g_bad_symbol
        $error("symbol width out of range");
    end
    if (CHANNEL_WIDTH < 0 || CHANNEL_WIDTH > 8 || MAX_CHANNELS < 0 || MAX_CHANNELS > 255)
    begin : g_bad_chan
        $error("channel setting out of range");
    end
    if (ERROR_WIDTH < 0 || ERROR_WIDTH > 31)
    begin : g_bad_err
        $error("error width out of range");
    end
    // Each option flag is a plain switch
    if (USE_PACKETS > 1 || USE_PACKETS < 0 || USE_CHANNEL > 1 || USE_CHANNEL < 0)
    begin : g_bad_flags
        $error("packet or channel option out of range");
    end
    if (USE_ERROR > 1 || USE_ERROR < 0)
    begin : g_bad_err_flag
        $error("error option out of range");
    end

    function automatic ssf_reg_t ssfDecode(input logic [11:0] addr);
        case (addr)
            `SSF_OFF_CTRL: ssfDecode = SSF_REG_CTRL;
            `SSF_OFF_STATUS: ssfDecode = SSF_REG_STATUS;
            `SSF_OFF_BEATS: ssfDecode = SSF_REG_BEATS;
            default: ssfDecode = SSF_REG_NONE;
        endcase
    endfunction : ssfDecode

    // Stream path stays combinational; registering it would add a cycle of latency
    logic allReady;
    logic gatedValid;
    assign allReady = &outReady;
    assign gatedValid = (QUALIFY_VALID == 1) ? (inValid & allReady) : inValid;
    assign inReady = allReady;

    always_comb
    begin
        for (int i = 0; i < FANOUT_COUNT; i++)
        begin
            outValid[i] = gatedValid;
            outData[i] = inData;
            outStartOfPacket[i] = (USE_PACKETS == 1) ? inStartOfPacket : 1'b0;
            outEndOfPacket[i] = (USE_PACKETS == 1) ? inEndOfPacket : 1'b0;
            outEmpty[i] = (USE_PACKETS == 1) ? inEmpty : '0;
            outChannel[i] = HAS_CHAN ? inChannel : '0;
            outError[i] = HAS_ERR ? inError : '0;
        end
    end

    // Observation registers sit beside the stream path, never in it
    ssf_state_t state_q;
    ssf_state_t state_d;
    ssf_apb_req_t req;
    ssf_reg_t hit;
    logic access;
    logic beatTaken;

    assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
    assign hit = ssfDecode(req.addr);
    assign access = req.sel & req.enable & ~state_q.ready;
    assign beatTaken = inValid & allReady;

    always_comb
    begin
        state_d = state_q;
        state_d.ready = access;
        state_d.slverr = access & (hit == SSF_REG_NONE);
        state_d.rdata = `SSF_RDATA_RESET;
        if (beatTaken)
        begin
            state_d.beats = state_q.beats + 32'h0000_0001;
        end
        // A clear that meets a new beat still counts that beat
        if (access && req.write && hit == SSF_REG_CTRL && req.wdata[`SSF_CTRL_CLR_BIT])
        begin
            state_d.beats = beatTaken ? 32'h0000_0001 : `SSF_BEATS_RESET;
        end
        if (access && !req.write)
        begin
            case (hit)
                SSF_REG_STATUS:
                begin
                    state_d.rdata[`SSF_STAT_INVALID_BIT] = inValid;
                    state_d.rdata[`SSF_STAT_INREADY_BIT] = allReady;
                    state_d.rdata[`SSF_STAT_OUTREADY_LSB +: FANOUT_COUNT] = outReady;
                end
                SSF_REG_BEATS: state_d.rdata = state_q.beats;
                default: state_d.rdata = `SSF_RDATA_RESET;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_q <= '{rdata: `SSF_RDATA_RESET, ready: 1'b0, slverr: 1'b0,
                beats: `SSF_BEATS_RESET};
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign prdata = state_q.rdata;
    assign pready = state_q.ready;
    assign pslverr = state_q.slverr;

    // Checks
    ready_and_a: assert property (@(posedge ref_clk) disable iff (rst)
        inReady == &outReady)
        else $error("input ready is not the AND of output readies");

    gate_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
        (QUALIFY_VALID == 1 && !(&outReady)) |-> (outValid == '0))
        else $error("valid not dropped under backpressure");

    plain_copy_a: assert property (@(posedge ref_clk) disable iff (rst)
        (QUALIFY_VALID == 0) |-> (outValid == {FANOUT_COUNT{inValid}}))
        else $error("ungated valid differs from input valid");

    same_cycle_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(inValid) && (&outReady) |-> (&outValid))
        else $error("valid did not follow input in the same cycle");

    gated_eq_a: assert property (@(posedge ref_clk) disable iff (rst)
        (QUALIFY_VALID == 1) |-> (outValid == {FANOUT_COUNT{inValid & (&outReady)}}))
        else $error("gated valid is wrong");

    data_copy_a: assert property (@(posedge ref_clk) disable iff (rst)
        outData == {FANOUT_COUNT{inData}})
        else $error("output data differs from input data");

    packet_copy_a: assert property (@(posedge ref_clk) disable iff (rst)
        (USE_PACKETS == 1) |-> (outStartOfPacket == {FANOUT_COUNT{inStartOfPacket}}
        && outEndOfPacket == {FANOUT_COUNT{inEndOfPacket}}
        && outEmpty == {FANOUT_COUNT{inEmpty}}))
        else $error("packet signals not copied");

    chan_copy_a: assert property (@(posedge ref_clk) disable iff (rst)
        outChannel == (HAS_CHAN ? {FANOUT_COUNT{inChannel}} : '0))
        else $error("channel not copied");

    err_copy_a: assert property (@(posedge ref_clk) disable iff (rst)
        outError == (HAS_ERR ? {FANOUT_COUNT{inError}} : '0))
        else $error("error not copied");

    beat_count_a: assert property (@(posedge ref_clk) disable iff (rst)
        beatTaken && !access |=> state_q.beats == $past(state_q.beats) + 32'h0000_0001)
        else $error("accepted beat not counted");

    apb_answer_a: assert property (@(posedge ref_clk) disable iff (rst)
        psel && !penable ##1 psel && penable |-> ##[0:1] pready)
        else $error("APB access not answered");

    packet_off_a: assert property (@(posedge ref_clk) disable iff (rst)
        (USE_PACKETS != 1) |-> (outStartOfPacket == '0 && outEndOfPacket == '0
        && outEmpty == '0))
        else $error("packet signals driven while packets are off");

    ready_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
        (outReady != '1) |-> !inReady)
        else $error("input ready high while an output stalls");

    ready_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
        (&outReady) |-> inReady)
        else $error("input ready low while every output is ready");

    ungated_stall_a: assert property (@(posedge ref_clk) disable iff (rst)
        (QUALIFY_VALID == 0 && inValid && outReady != '1) |-> (&outValid))
        else $error("ungated valid dropped under backpressure");

    // Register side: one answer per access, data only while it stands
    ready_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
        pready |=> !pready)
        else $error("bus answer held longer than one cycle");

    err_with_ready_a: assert property (@(posedge ref_clk) disable iff (rst)
        pslverr |-> pready)
        else $error("error flag without an answer");

    rdata_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
        !pready |-> (prdata == '0))
        else $error("read data shown outside an answer");

    beats_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        access && !pwrite && hit == SSF_REG_BEATS |=> prdata == $past(state_q.beats))
        else $error("beat count read back wrong");

    status_read_a: assert property (@(posedge ref_clk) disable iff (rst)
        access && !pwrite && hit == SSF_REG_STATUS
        |=> prdata[`SSF_STAT_INREADY_BIT] == $past(inReady)
        && prdata[`SSF_STAT_INVALID_BIT] == $past(inValid))
        else $error("status read back wrong");

    clear_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
        access && pwrite && hit == SSF_REG_CTRL && pwdata[`SSF_CTRL_CLR_BIT] && !beatTaken
        |=> state_q.beats == `SSF_BEATS_RESET)
        else $error("clear did not empty the beat count");

    clear_beat_a: assert property (@(posedge ref_clk) disable iff (rst)
        access && pwrite && hit == SSF_REG_CTRL && pwdata[`SSF_CTRL_CLR_BIT] && beatTaken
        |=> state_q.beats == 32'h0000_0001)
        else $error("beat lost when it met a clear");

    beat_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        !beatTaken && !access |=> $stable(state_q.beats))
        else $error("beat count moved without a beat");

    beat_c: cover property (@(posedge ref_clk) disable iff (rst) inValid && inReady);
    stall_c: cover property (@(posedge ref_clk) disable iff (rst)
        inValid && !inReady ##1 inValid && inReady);
    read_c: cover property (@(posedge ref_clk) disable iff (rst) pready && !pwrite && !pslverr);
    bad_addr_c: cover property (@(posedge ref_clk) disable iff (rst) pready && pslverr);
    clear_c: cover property (@(posedge ref_clk) disable iff (rst)
        access && pwrite && hit == SSF_REG_CTRL);

endmodule : ssf_splitter_fanout

`default_nettype wire

// ===== tb/ssf_sink_model.sv
`timescale 1ns/1ps
`default_nettype none

module ssf_sink_model #(
    parameter int N = 2
) (
    // Clock
    input wire logic ref_clk,
    // Stall control
    input wire logic randomMode,
    input wire logic [N-1:0] holdLow,
    // Sink readies
    output logic [N-1:0] outReady
);
    logic [N-1:0] rdyRaw_q;
    initial rdyRaw_q = '1;
    // Random stalls change only at the edge, as a real sink would
    always @(posedge ref_clk)
    begin
        rdyRaw_q <= randomMode ? N'($urandom) : '1;
    end
    assign outReady = rdyRaw_q & ~holdLow;
endmodule : ssf_sink_model

`default_nettype wire

// ===== tb/test_ssf_splitter_fanout.sv
`timescale 1ns/1ps
`default_nettype none

module test_ssf_splitter_fanout;
    logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, er, inValid = 0, inReady, inReady2, inSop = 0, inEop = 0;
    logic randomMode = 0;
    logic [0:0] inEmpty = '0;
    logic [15:0] inData = '0;
    logic [3:0] inChannel = '0;
    logic [2:0] inError = '0;
    logic [1:0] outValid, outValid2, outReady, holdLow = '0, outSop, outEop;
    logic [1:0][15:0] outData;
    logic [1:0][0:0] outEmpty;
    logic [1:0][3:0] outChannel;
    logic [1:0][2:0] outError;
    logic [31:0] prdata2, rd2;
    logic pready2, pslverr2, er2;
    logic [1:0] outSop2, outEop2;
    logic [1:0][15:0] outData2;
    logic [1:0][0:0] outEmpty2, outChan2, outErr2;
    int n_mismatch = 0, num_checks = 0, beats = 0;

    initial forever #2.5 ref_clk = ~ref_clk;

    ssf_splitter_fanout #(.DATA_WIDTH(16), .USE_PACKETS(1), .USE_CHANNEL(1),
        .CHANNEL_WIDTH(4), .USE_ERROR(1), .ERROR_WIDTH(3)) uut (.ref_clk(ref_clk),
        .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .inValid(inValid), .inReady(inReady), .inData(inData), .inStartOfPacket(inSop),
        .inEndOfPacket(inEop), .inEmpty(inEmpty), .inChannel(inChannel),
        .inError(inError), .outValid(outValid), .outReady(outReady), .outData(outData),
        .outStartOfPacket(outSop), .outEndOfPacket(outEop), .outEmpty(outEmpty),
        .outChannel(outChannel), .outError(outError));
    // Second copy without gating shares every input, so its idle options are checked too
    ssf_splitter_fanout #(.DATA_WIDTH(16), .QUALIFY_VALID(0)) uut2 (.ref_clk(ref_clk),
        .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata2), .pready(pready2), .pslverr(pslverr2),
        .inValid(inValid), .inReady(inReady2), .inData(inData), .inStartOfPacket(inSop),
        .inEndOfPacket(inEop), .inEmpty(inEmpty), .inChannel(inChannel[0]),
        .inError(inError[0]), .outValid(outValid2), .outReady(outReady),
        .outData(outData2), .outStartOfPacket(outSop2), .outEndOfPacket(outEop2),
        .outEmpty(outEmpty2), .outChannel(outChan2), .outError(outErr2));
    ssf_sink_model #(.N(2)) sink (.ref_clk(ref_clk), .randomMode(randomMode),
        .holdLow(holdLow), .outReady(outReady));

    task summarize;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Master holds the request until pready is sampled high at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 50)
        begin
            n_mismatch++;
            summarize();
        end
        rd = prdata;
        er = pslverr;
        rd2 = prdata2;
        er2 = pslverr2;
        chk("pready2", 32'h1, {31'h0, pready2});
        psel <= 0;
        penable <= 0;
    endtask : apb

    task step(input logic rnd, input logic [1:0] hold);
        logic allRdy;
        @(posedge ref_clk);
        randomMode <= rnd;
        holdLow <= hold;
        inValid <= rnd ? 1'($urandom) : 1'b1;
        if (rnd)
        begin
            inData <= 16'($urandom);
            inSop <= 1'($urandom);
            inEop <= 1'($urandom);
            inEmpty <= 1'($urandom);
            inChannel <= 4'($urandom);
            inError <= 3'($urandom);
        end
        @(negedge ref_clk);
        allRdy = &outReady;
        chk("inReady", allRdy, inReady);
        chk("inReadyUngated", allRdy, inReady2);
        chk("outValid", {2{inValid & allRdy}}, outValid);
        chk("outValidUngated", {2{inValid}}, outValid2);
        for (int i = 0; i < 2; i++)
        begin
            chk("outData", inData, outData[i]);
            chk("outPacket", {inSop, inEop, inEmpty}, {outSop[i], outEop[i], outEmpty[i]});
            chk("outChannel", inChannel, outChannel[i]);
            chk("outError", inError, outError[i]);
            chk("outData2", inData, outData2[i]);
            chk("outPacket2", 32'h0, {outSop2[i], outEop2[i], outEmpty2[i]});
            chk("outSide2", 32'h0, {outChan2[i], outErr2[i]});
        end
        if (inValid && allRdy)
            beats++;
    endtask : step

    initial
    begin
        void'($urandom(1));
        repeat (2) @(posedge ref_clk);
        rst <= 0;
        apb(0, 12'h008, '0);
        chk("beatsReset", 32'h0, rd);
        chk("beatsReset2", 32'h0, rd2);
        apb(0, 12'h00c, '0);
        chk("unmappedErr", 32'h1, {31'h0, er});
        chk("unmappedData", 32'h0, rd);
        chk("unmappedErr2", 32'h1, {31'h0, er2});
        // No lane stalls, then each lane stalls alone, then both at once
        for (int m = 0; m < 4; m++)
        begin
            step(0, 2'(m));
        end
        repeat (300) step(1, 2'b00);
        step(0, 2'b10);
        apb(0, 12'h004, '0);
        chk("status", 32'h0001_0001, rd);
        chk("status2", 32'h0001_0001, rd2);
        chk("statusErr", 32'h0, {31'h0, er});
        apb(0, 12'h008, '0);
        chk("beats", beats, rd);
        chk("beats2", beats, rd2);
        apb(1, 12'h000, 32'h1);
        apb(0, 12'h008, '0);
        chk("beatsCleared", 32'h0, rd);
        chk("beatsCleared2", 32'h0, rd2);
        summarize();
    end
endmodule : test_ssf_splitter_fanout

`default_nettype wire
